// File: pd_ctl_regs.svh
`ifndef PD_CTL_REGS_SVH
`define PD_CTL_REGS_SVH
`define MT_GOODCRC 4'h1
`define MT_GOTOMIN 4'h2
`define MT_ACCEPT 4'h3
`define MT_REJECT 4'h4
`define MT_PING 4'h5
`define MT_PSRDY 4'h6
`define MT_GETSRC 4'h7
`define MT_GETSNK 4'h8
`define MT_DRSWAP 4'h9
`define MT_PRSWAP 4'hA
`define MT_VCSWAP 4'hB
`define MT_WAIT 4'hC
`define MT_SOFTRST 4'hD
`define DT_REQUEST 4'h2
`define ROLE_UFP 1'b0
`define ROLE_DFP 1'b1
`define T_TRANSMIT_NS 195000
`define T_RESPONSE_NS 15000000
`define T_ACTIVITY_NS 50000000
`define T_SNKPWR_NS 15000000
`define CLK_NS 10
`endif

// File: pd_ctl_pkg.sv
`default_nettype none
package pd_ctl_pkg;
  typedef logic [3:0] msg_type_t;
  typedef logic [2:0] msg_id_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND} tx_state_t;
endpackage : pd_ctl_pkg
`default_nettype wire

// File: pd_control_message_responder.sv
`timescale 1ns/1ps
`default_nettype none
`include "pd_ctl_regs.svh"
module pd_control_message_responder #(
  parameter int TX_CYC = `T_TRANSMIT_NS / `CLK_NS,
  parameter int RESP_CYC = `T_RESPONSE_NS / `CLK_NS,
  parameter int ACT_CYC = `T_ACTIVITY_NS / `CLK_NS,
  parameter int SNK_CYC = `T_SNKPWR_NS / `CLK_NS
) (
  input wire logic sys_clk, // 100 MHz
  input wire logic rstn, // sync, active low
  input wire logic hard_reset, // hard reset seen
  input wire logic init_source, // power role strap
  input wire logic init_dfp, // data role strap
  input wire logic rx_valid, // received message, pulse
  input wire logic rx_crc_ok, // its crc checked good
  input wire pd_ctl_pkg::msg_type_t rx_type, // type field
  input wire logic [2:0] rx_ndo, // data object count
  input wire pd_ctl_pkg::msg_id_t rx_id, // message id
  input wire logic bist_mode, // test stream running
  input wire logic tx_done, // transmit finished, pulse
  input wire logic dual_role, // dual role capable
  input wire logic pd_mode, // in power delivery mode
  input wire logic contract, // explicit contract held
  input wire logic at_safe5v, // sourcing safe 5 V
  input wire logic in_ready, // source/sink ready state
  input wire logic req_ok, // policy can meet request
  input wire logic req_giveback, // request give-back flag
  input wire logic harvest, // meet give-back request by GotoMin
  input wire logic swap_ok, // policy agrees to swaps
  input wire logic swap_wait, // policy defers swaps
  input wire logic supply_done, // supply settled, pulse
  input wire logic prs_done, // power swap done, pulse
  input wire logic giveback_done, // borrowed power back
  output logic tx_valid, // transmit request
  output pd_ctl_pkg::msg_type_t tx_type, // type to send
  output pd_ctl_pkg::msg_id_t tx_id, // id to send
  output logic tx_drole, // header data role bit
  output logic tx_prole, // header power role bit
  output logic cc_pullup, // 1 pull-up, 0 pull-down
  output logic usb_reattach, // reattach pulse
  output logic mode_exit, // exit alt modes pulse
  output logic retry_clr, // clear retry count pulse
  output logic caps_clr, // clear caps count pulse
  output logic src_caps_req, // send source caps pulse
  output logic snk_caps_req, // send sink caps pulse
  output logic ack_late, // ack deadline missed
  output logic resp_late, // reply deadline missed
  output logic alloc_ok, // new power may be given
  output logic snk_settled // sink new power time up
);
  import pd_ctl_pkg::*;

  if (TX_CYC < 1 || RESP_CYC < 1 || ACT_CYC < 1 || SNK_CYC < 1) begin : g_bad_cyc
    $error("timer counts must be at least one cycle");
  end

  // ----------------------------------------
  // receive decode
  // ----------------------------------------
  function automatic logic is_ctl(input logic [2:0] ndo, input msg_type_t t, input msg_type_t c);
    is_ctl = (ndo == 3'h0) && (t == c);
  endfunction : is_ctl

  wire logic rx_good = rx_valid && rx_crc_ok;
  wire logic rx_new = rx_good && !bist_mode;
  wire logic rx_gcrc = rx_new && is_ctl(rx_ndo, rx_type, `MT_GOODCRC);
  wire logic rx_req = rx_new && (rx_ndo != 3'h0) && (rx_type == `DT_REQUEST);
  wire logic rx_gsrc = rx_new && is_ctl(rx_ndo, rx_type, `MT_GETSRC);
  wire logic rx_gsnk = rx_new && is_ctl(rx_ndo, rx_type, `MT_GETSNK);
  wire logic rx_dr = rx_new && is_ctl(rx_ndo, rx_type, `MT_DRSWAP);
  wire logic rx_pr = rx_new && is_ctl(rx_ndo, rx_type, `MT_PRSWAP);
  wire logic rx_vc = rx_new && is_ctl(rx_ndo, rx_type, `MT_VCSWAP);
  wire logic rx_srst = rx_new && is_ctl(rx_ndo, rx_type, `MT_SOFTRST);

  // ----------------------------------------
  // state
  // ----------------------------------------
  tx_state_t st_q, st_d;
  logic ack_pend_q, rep_pend_q, psr_pend_q, ping_pend_q;
  msg_id_t ack_id_q, msgid_q;
  msg_type_t rep_type_q;
  logic prole_q, drole_q;
  logic dr_acc_q, pr_acc_q, gm_sent_q, borrowed_q;
  logic [31:0] ack_cnt_q, resp_cnt_q, act_cnt_q, snk_cnt_q;
  logic snk_run_q;

  // reply choice; reserved codes and pings leave it empty
  wire logic swap_take = swap_ok && in_ready;
  wire msg_type_t swap_ans = swap_take ? `MT_ACCEPT : (swap_wait ? `MT_WAIT : `MT_REJECT);
  wire logic gm_ok = harvest && req_giveback;
  wire msg_type_t req_ans = !req_ok ? `MT_REJECT : (gm_ok ? `MT_GOTOMIN : `MT_ACCEPT);
  wire logic rep_new = (rx_req && prole_q) || rx_dr || rx_pr || rx_vc || rx_srst
                       || (rx_gsrc && !prole_q && !dual_role)
                       || (rx_gsnk && prole_q && !dual_role);
  wire msg_type_t rep_sel = rx_req ? req_ans
                          : (rx_dr || rx_pr) ? swap_ans
                          : rx_srst ? `MT_ACCEPT
                          : `MT_REJECT;

  // ping gating
  wire logic ping_allow = prole_q && contract && pd_mode && !(at_safe5v && in_ready);
  wire logic act_hit = act_cnt_q >= (ACT_CYC - 1);

  // transmit selection: ack first, then reply, PS_RDY, ping
  wire logic sel_ack = ack_pend_q;
  wire logic sel_rep = !ack_pend_q && rep_pend_q;
  wire logic sel_psr = !ack_pend_q && !rep_pend_q && psr_pend_q;
  wire logic sel_ping = !ack_pend_q && !rep_pend_q && !psr_pend_q && ping_pend_q;
  wire logic sel_any = sel_ack || sel_rep || sel_psr || sel_ping;
  wire logic start = (st_q == ST_IDLE) && sel_any;
  wire msg_type_t sel_type = sel_ack ? `MT_GOODCRC
                           : sel_rep ? rep_type_q
                           : sel_psr ? `MT_PSRDY
                           : `MT_PING;
  wire logic sent = (st_q == ST_SEND) && tx_done;
  wire logic sent_acc = sent && (tx_type == `MT_ACCEPT);
  wire logic dr_flip = sent_acc && dr_acc_q;
  wire logic pr_flip = prs_done && pr_acc_q;
  wire logic id_clr = rx_srst || hard_reset || pr_flip;
  wire logic id_inc = rx_gcrc && (rx_id == msgid_q);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (sel_any) begin
          st_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_done) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // transmit and pending flags
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      tx_valid <= 1'b0;
      tx_type <= 4'h0;
      tx_id <= 3'h0;
    end else begin
      st_q <= st_d;
      tx_valid <= start || (tx_valid && !tx_done);
      if (start) begin
        tx_type <= sel_type;
        tx_id <= sel_ack ? ack_id_q : msgid_q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ack_pend_q <= 1'b0;
      ack_id_q <= 3'h0;
      rep_pend_q <= 1'b0;
      rep_type_q <= 4'h0;
      psr_pend_q <= 1'b0;
      ping_pend_q <= 1'b0;
    end else begin
      // new arrival wins over a clear in the same cycle
      ack_pend_q <= rx_new || (ack_pend_q && !(start && sel_ack));
      if (rx_new) begin
        ack_id_q <= rx_id;
      end
      rep_pend_q <= rep_new || (rep_pend_q && !(start && sel_rep));
      if (rep_new) begin
        rep_type_q <= rep_sel;
      end
      psr_pend_q <= supply_done || (psr_pend_q && !(start && sel_psr));
      ping_pend_q <= ping_allow && ((act_hit && !ping_pend_q) || (ping_pend_q && !(start && sel_ping)));
    end
  end

  // ----------------------------------------
  // message id, roles, swaps
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      msgid_q <= 3'h0;
    end else if (id_clr) begin
      msgid_q <= 3'h0;
    end else if (id_inc) begin
      msgid_q <= 3'(msgid_q + 3'h1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prole_q <= init_source;
      drole_q <= init_dfp;
      dr_acc_q <= 1'b0;
      pr_acc_q <= 1'b0;
    end else begin
      if (dr_flip) begin
        drole_q <= ~drole_q;
      end
      if (pr_flip) begin
        prole_q <= ~prole_q;
      end
      if (rep_new) begin
        dr_acc_q <= rx_dr && swap_take;
      end else if (dr_flip) begin
        dr_acc_q <= 1'b0;
      end
      if (rep_new && rx_pr) begin
        pr_acc_q <= swap_take;
      end else if (pr_flip || hard_reset) begin
        pr_acc_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // outputs of swaps and queries
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_drole <= `ROLE_UFP;
      tx_prole <= 1'b0;
      cc_pullup <= 1'b0;
      usb_reattach <= 1'b0;
      mode_exit <= 1'b0;
      retry_clr <= 1'b0;
      caps_clr <= 1'b0;
      src_caps_req <= 1'b0;
      snk_caps_req <= 1'b0;
    end else begin
      tx_drole <= drole_q;
      tx_prole <= prole_q;
      cc_pullup <= prole_q;
      usb_reattach <= dr_flip;
      mode_exit <= dr_flip;
      retry_clr <= pr_flip || rx_srst;
      caps_clr <= pr_flip && !prole_q;
      src_caps_req <= rx_gsrc && (prole_q || dual_role);
      snk_caps_req <= rx_gsnk && (!prole_q || dual_role);
    end
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ack_cnt_q <= 32'h0000_0000;
      resp_cnt_q <= 32'h0000_0000;
      act_cnt_q <= 32'h0000_0000;
      ack_late <= 1'b0;
      resp_late <= 1'b0;
    end else begin
      ack_cnt_q <= (rx_new || !ack_pend_q) ? 32'h0000_0000 : ack_cnt_q + 32'h0000_0001;
      ack_late <= ack_pend_q && !start && (ack_cnt_q >= 32'(TX_CYC - 1));
      resp_cnt_q <= (rep_new || !rep_pend_q) ? 32'h0000_0000 : resp_cnt_q + 32'h0000_0001;
      resp_late <= rep_pend_q && (resp_cnt_q >= 32'(RESP_CYC - 1));
      act_cnt_q <= (rx_valid || tx_valid || act_hit) ? 32'h0000_0000 : act_cnt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // power harvesting
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      gm_sent_q <= 1'b0;
      borrowed_q <= 1'b0;
      snk_run_q <= 1'b0;
      snk_cnt_q <= 32'h0000_0000;
      alloc_ok <= 1'b0;
      snk_settled <= 1'b0;
    end else begin
      gm_sent_q <= sent && (tx_type == `MT_GOTOMIN);
      borrowed_q <= gm_sent_q || (borrowed_q && !giveback_done);
      alloc_ok <= !borrowed_q && !gm_sent_q;
      snk_run_q <= gm_sent_q || (snk_run_q && snk_cnt_q < 32'(SNK_CYC - 1));
      snk_cnt_q <= snk_run_q ? snk_cnt_q + 32'h0000_0001 : 32'h0000_0000;
      snk_settled <= snk_run_q && (snk_cnt_q == 32'(SNK_CYC - 1));
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int ACK_MAX = 4;

  property p_no_bad_ack;
    @(posedge sys_clk) disable iff (!rstn)
      (rx_valid && !rx_crc_ok && !ack_pend_q && st_q == ST_IDLE) |=> !ack_pend_q;
  endproperty
  a_no_bad_ack: assert property (p_no_bad_ack) else $error("ack queued for bad crc");

  property p_ack_id;
    @(posedge sys_clk) disable iff (!rstn)
      (start && sel_ack) |=> (tx_type == `MT_GOODCRC && tx_id == $past(ack_id_q));
  endproperty
  a_ack_id: assert property (p_ack_id) else $error("ack id mismatch");

  property p_ack_quick;
    @(posedge sys_clk) disable iff (!rstn)
      (rx_new && st_q == ST_IDLE && !sel_any) |=> ##[0:ACK_MAX] (tx_valid && tx_type == `MT_GOODCRC);
  endproperty
  a_ack_quick: assert property (p_ack_quick) else $error("ack not started in time");

  property p_bist_quiet;
    @(posedge sys_clk) disable iff (!rstn)
      (bist_mode && rx_valid && !ack_pend_q && st_q == ST_IDLE) |=> !ack_pend_q;
  endproperty
  a_bist_quiet: assert property (p_bist_quiet) else $error("ack during test stream");

  property p_gm_giveback;
    @(posedge sys_clk) disable iff (!rstn)
      (rep_new && rep_sel == `MT_GOTOMIN) |-> (req_giveback && harvest);
  endproperty
  a_gm_giveback: assert property (p_gm_giveback) else $error("GotoMin without give-back");

  property p_ping_gate;
    @(posedge sys_clk) disable iff (!rstn)
      (!pd_mode || !contract) |=> !ping_pend_q;
  endproperty
  a_ping_gate: assert property (p_ping_gate) else $error("ping outside allowed mode");

  property p_dr_flip;
    @(posedge sys_clk) disable iff (!rstn)
      dr_flip |=> (drole_q != $past(drole_q) && usb_reattach && mode_exit) ##1 (tx_drole == drole_q);
  endproperty
  a_dr_flip: assert property (p_dr_flip) else $error("data role not inverted");

  property p_cc_follow;
    @(posedge sys_clk) disable iff (!rstn)
      pr_flip |=> ##1 (cc_pullup == prole_q && cc_pullup != $past(cc_pullup, 2));
  endproperty
  a_cc_follow: assert property (p_cc_follow) else $error("termination not swapped");

  property p_id_clear;
    @(posedge sys_clk) disable iff (!rstn)
      id_clr |=> (msgid_q == 3'h0);
  endproperty
  a_id_clear: assert property (p_id_clear) else $error("message id not cleared");

  property p_no_alloc;
    @(posedge sys_clk) disable iff (!rstn)
      borrowed_q |=> !alloc_ok;
  endproperty
  a_no_alloc: assert property (p_no_alloc) else $error("allocation while borrowed");
endmodule : pd_control_message_responder
`default_nettype wire

// File: link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  input wire logic sys_clk, // 100 MHz
  input wire logic slow, // long transmit time
  input wire logic tx_valid, // request from the block
  output logic tx_done // transmission finished
);
  logic done_q = 1'b0;
  int cnt = 0;
  assign tx_done = done_q;
  // ----------------------------------------
  // one completion per request, quick or slow
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (done_q) begin
      done_q <= 1'b0;
      cnt <= 0;
    end else if (tx_valid) begin
      if (cnt >= (slow ? 6 : 1)) done_q <= 1'b1;
      else cnt <= cnt + 1;
    end else begin
      cnt <= 0;
    end
  end
endmodule : link_partner
`default_nettype wire

// File: pd_control_message_responder_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pd_ctl_regs.svh"
module pd_control_message_responder_bench;
  import pd_ctl_pkg::*;
  logic sys_clk, rstn, hard_reset, init_source, init_dfp, rx_valid, rx_crc_ok, bist_mode;
  logic tx_done, dual_role, pd_mode, contract, at_safe5v, in_ready, req_ok, req_giveback;
  logic harvest, swap_ok, swap_wait, supply_done, prs_done, giveback_done, slow;
  logic tx_valid, tx_drole, tx_prole, cc_pullup, usb_reattach, mode_exit, retry_clr, caps_clr;
  logic src_caps_req, snk_caps_req, ack_late, resp_late, alloc_ok, snk_settled;
  logic [2:0] rx_ndo;
  logic [6:0] seen;
  logic late_seen;
  msg_type_t rx_type, tx_type;
  msg_id_t rx_id, tx_id, my_id;
  int num_errors, n_checks;
  // ----------------------------------------
  // design, link partner, clock
  // ----------------------------------------
  pd_control_message_responder #(.TX_CYC(8), .RESP_CYC(20), .ACT_CYC(50), .SNK_CYC(20)) dut (
    .sys_clk, .rstn, .hard_reset, .init_source, .init_dfp, .rx_valid, .rx_crc_ok, .rx_type,
    .rx_ndo, .rx_id, .bist_mode, .tx_done, .dual_role, .pd_mode, .contract, .at_safe5v,
    .in_ready, .req_ok, .req_giveback, .harvest, .swap_ok, .swap_wait, .supply_done,
    .prs_done, .giveback_done, .tx_valid, .tx_type, .tx_id, .tx_drole, .tx_prole, .cc_pullup,
    .usb_reattach, .mode_exit, .retry_clr, .caps_clr, .src_caps_req, .snk_caps_req,
    .ack_late, .resp_late, .alloc_ok, .snk_settled);
  link_partner partner (.sys_clk, .slow, .tx_valid, .tx_done);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // sticky record of the single-cycle pulses and the deadline flags
  always @(posedge sys_clk) begin
    if (rstn) begin
      seen <= seen | {snk_settled, snk_caps_req, src_caps_req, caps_clr, retry_clr, mode_exit,
        usb_reattach};
      late_seen <= late_seen | ack_late | resp_late;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task send(input msg_type_t t, input logic [2:0] n, input msg_id_t id, input logic ok);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_type <= t;
    rx_ndo <= n;
    rx_id <= id;
    rx_crc_ok <= ok;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
  endtask : send
  task expect_tx(input msg_type_t t, input msg_id_t id, input int lim);
    int i;
    i = 0;
    while (i < lim && tx_valid !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk(tx_valid === 1'b1 && tx_type === t && tx_id === id, "wrong or missing message");
    i = 0;
    while (i < 20 && tx_valid === 1'b1) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
  endtask : expect_tx
  task none(input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      hit = hit | (tx_valid !== 1'b0);
    end
    chk(!hit, "unexpected message");
  endtask : none
  task rx_ctl(input msg_type_t t, input logic [2:0] n, input msg_id_t id);
    #1;
    seen = '0;
    send(t, n, id, 1'b1);
    expect_tx(`MT_GOODCRC, id, 8);
  endtask : rx_ctl
  task pol(input logic ok, input logic rdy, input logic wt);
    @(posedge sys_clk);
    swap_ok <= ok;
    in_ready <= rdy;
    swap_wait <= wt;
  endtask : pol
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  msg_type_t rsv_codes[3] = '{4'h0, 4'hE, 4'hF};
  task t_ack;
    send(`MT_PING, 3'd0, 3'd5, 1'b0);
    none(12);
    @(posedge sys_clk) bist_mode <= 1'b1;
    send(`MT_PING, 3'd0, 3'd6, 1'b1);
    none(12);
    @(posedge sys_clk) bist_mode <= 1'b0;
    rx_ctl(`MT_PING, 3'd0, 3'd5);
    none(25);
    foreach (rsv_codes[k]) begin
      rx_ctl(rsv_codes[k], 3'd0, 3'(k));
      none(25);
    end
    $display("done t_ack");
  endtask : t_ack
  task t_request;
    logic [2:0] row[4] = '{3'b000, 3'b100, 3'b110, 3'b111};
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      {req_ok, harvest, req_giveback} <= row[k];
      rx_ctl(`DT_REQUEST, 3'd1, 3'(k));
      expect_tx(k == 0 ? `MT_REJECT : (k == 3 ? `MT_GOTOMIN : `MT_ACCEPT), my_id, 14);
    end
    repeat (3) @(posedge sys_clk);
    chk(alloc_ok === 1'b0, "power allocatable while borrowed");
    repeat (25) @(posedge sys_clk);
    chk(seen[6] === 1'b1, "sink settle time not reported");
    @(posedge sys_clk) supply_done <= 1'b1;
    @(posedge sys_clk) supply_done <= 1'b0;
    expect_tx(`MT_PSRDY, my_id, 8);
    @(posedge sys_clk) giveback_done <= 1'b1;
    @(posedge sys_clk) giveback_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(alloc_ok === 1'b1, "allocation not restored");
    $display("done t_request");
  endtask : t_request
  task t_caps;
    @(posedge sys_clk) dual_role <= 1'b0;
    rx_ctl(`MT_GETSRC, 3'd0, 3'd1);
    none(6);
    chk(seen[4] === 1'b1, "no source caps request");
    rx_ctl(`MT_GETSNK, 3'd0, 3'd2);
    expect_tx(`MT_REJECT, my_id, 14);
    @(posedge sys_clk) dual_role <= 1'b1;
    rx_ctl(`MT_GETSNK, 3'd0, 3'd3);
    none(6);
    chk(seen[5] === 1'b1, "no sink caps request");
    $display("done t_caps");
  endtask : t_caps
  task t_drswap;
    @(posedge sys_clk) slow <= 1'b1;
    pol(1'b0, 1'b1, 1'b1);
    rx_ctl(`MT_DRSWAP, 3'd0, 3'd4);
    expect_tx(`MT_WAIT, my_id, 20);
    pol(1'b0, 1'b1, 1'b0);
    rx_ctl(`MT_DRSWAP, 3'd0, 3'd5);
    expect_tx(`MT_REJECT, my_id, 20);
    pol(1'b1, 1'b0, 1'b0);
    rx_ctl(`MT_DRSWAP, 3'd0, 3'd6);
    expect_tx(`MT_REJECT, my_id, 20);
    chk(tx_drole === 1'b1 && seen[0] === 1'b0, "swap action after refusal");
    pol(1'b1, 1'b1, 1'b0);
    rx_ctl(`MT_DRSWAP, 3'd0, 3'd7);
    expect_tx(`MT_ACCEPT, my_id, 20);
    repeat (4) @(posedge sys_clk);
    chk(tx_drole === 1'b0 && seen[1:0] === 2'b11, "data role or reattach wrong");
    chk(tx_prole === 1'b1 && cc_pullup === 1'b1, "power side changed");
    @(posedge sys_clk) slow <= 1'b0;
    $display("done t_drswap");
  endtask : t_drswap
  task t_prswap;
    rx_ctl(`MT_VCSWAP, 3'd0, 3'd0);
    expect_tx(`MT_REJECT, my_id, 14);
    for (int k = 0; k < 2; k++) begin
      rx_ctl(`MT_PRSWAP, 3'd0, 3'(k + 1));
      expect_tx(`MT_ACCEPT, my_id, 14);
      @(posedge sys_clk) prs_done <= 1'b1;
      @(posedge sys_clk) prs_done <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(tx_prole === 1'(k) && cc_pullup === 1'(k), "power role or CC wrong");
      chk(tx_drole === 1'b0 && seen[2] === 1'b1, "role kept or retry clear wrong");
      chk(seen[3] === 1'(k), "caps clear wrong");
    end
    $display("done t_prswap");
  endtask : t_prswap
  task t_msgid;
    @(posedge sys_clk) dual_role <= 1'b0;
    send(`MT_GOODCRC, 3'd0, 3'd0, 1'b1);
    repeat (12) @(posedge sys_clk);
    rx_ctl(`MT_GETSNK, 3'd0, 3'd1);
    expect_tx(`MT_REJECT, 3'd1, 14);
    rx_ctl(`MT_SOFTRST, 3'd0, 3'd2);
    expect_tx(`MT_ACCEPT, 3'd0, 14);
    send(`MT_GOODCRC, 3'd0, 3'd3, 1'b1);
    repeat (12) @(posedge sys_clk);
    rx_ctl(`MT_GETSNK, 3'd0, 3'd3);
    expect_tx(`MT_REJECT, 3'd0, 14);
    send(`MT_GOODCRC, 3'd0, 3'd0, 1'b1);
    repeat (12) @(posedge sys_clk);
    @(posedge sys_clk) hard_reset <= 1'b1;
    @(posedge sys_clk) hard_reset <= 1'b0;
    rx_ctl(`MT_GETSNK, 3'd0, 3'd4);
    expect_tx(`MT_REJECT, 3'd0, 14);
    $display("done t_msgid");
  endtask : t_msgid
  task t_ping;
    pol(1'b0, 1'b1, 1'b0);
    @(posedge sys_clk);
    {contract, pd_mode, at_safe5v} <= 3'b111;
    none(120);
    @(posedge sys_clk) at_safe5v <= 1'b0;
    expect_tx(`MT_PING, 3'd0, 60);
    @(posedge sys_clk) pd_mode <= 1'b0;
    none(120);
    @(posedge sys_clk) contract <= 1'b0;
    chk(late_seen === 1'b0, "deadline flag raised");
    $display("done t_ping");
  endtask : t_ping
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {rstn, hard_reset, rx_valid, rx_crc_ok, bist_mode, dual_role, pd_mode, contract} = '0;
    {at_safe5v, in_ready, req_ok, req_giveback, harvest, swap_ok, swap_wait} = '0;
    {supply_done, prs_done, giveback_done, slow} = '0;
    {init_source, init_dfp} = 2'b11;
    {rx_type, rx_ndo, rx_id} = '0;
    {num_errors, n_checks} = '0;
    seen = '0;
    late_seen = 1'b0;
    my_id = 3'd0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(tx_prole === 1'b1 && cc_pullup === 1'b1 && tx_drole === 1'b1, "straps not loaded");
    chk(alloc_ok === 1'b1 && tx_valid === 1'b0, "idle state wrong");
    t_ack();
    t_request();
    t_caps();
    t_drswap();
    t_prswap();
    t_msgid();
    t_ping();
    end_of_test();
  end
  initial begin
    #100000;
    num_errors++;
    $display("BAD %0t timeout", $time);
    end_of_test();
  end
endmodule : pd_control_message_responder_bench
`default_nettype wire
